// ---- rtl/mem_port_access_defs.svh ----
`ifndef MEM_PORT_ACCESS_DEFS_SVH
`define MEM_PORT_ACCESS_DEFS_SVH

// ************************************************************
// Register byte addresses
// ************************************************************
`define ADDR_INSTR_TIGHT_MEM_CTRL 32'hE000EF90
`define ADDR_DATA_TIGHT_MEM_CTRL 32'hE000EF94
`define ADDR_PERIPH_PORT_CTRL 32'hE000EF98
`define ADDR_CACHE_CTRL 32'hE000EF9C
`define ADDR_SLAVE_PORT_PRIORITY_CTRL 32'hE000EFA0
`define ADDR_AUX_BUS_FAULT_STATUS 32'hE000EFA8

// ************************************************************
// Field positions
// ************************************************************
`define TM_SIZE_MSB 6
`define TM_SIZE_LSB 3
`define TM_RETRY_BIT 2
`define TM_RMW_BIT 1
`define TM_ENABLE_BIT 0
`define PP_SIZE_MSB 3
`define PP_SIZE_LSB 1
`define PP_ENABLE_BIT 0
`define CC_FORCE_WT_BIT 2
`define CC_ECC_DIS_BIT 1
`define CC_SHARED_WT_BIT 0
`define SP_INIT_COUNT_MSB 15
`define SP_INIT_COUNT_LSB 11
`define SP_CTL_MSB 1
`define SP_CTL_LSB 0
`define AF_VALID_MSB 9
`define AF_STICKY_MSB 4

// ************************************************************
// Size codes and reset values
// ************************************************************
`define TM_SIZE_ABSENT 4'h0
`define TM_SIZE_MIN 4'h3
`define TM_SIZE_MAX 4'hF
`define PP_SIZE_MIN 3'h1
`define PP_SIZE_MAX 3'h4
`define CACHE_CTRL_RST_ECC 32'h00000000
`define CACHE_CTRL_RST_NO_ECC 32'h00000002
`define SLAVE_PRIO_RST 32'h00000000
`define AUX_FAULT_RST 32'h00000000

`endif

// ---- rtl/mem_port_access_pkg.sv ----
package mem_port_access_pkg;
  typedef enum logic [1:0] {
    ROUTE_TIGHT = 2'h1,
    ROUTE_AXI = 2'h2
  } route_t;
  typedef logic [31:0] word_t;
endpackage : mem_port_access_pkg

// ---- rtl/tight_mem_ctrl_reg.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "mem_port_access_defs.svh"
module tight_mem_ctrl_reg
  import mem_port_access_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [3:0] size_code,
  input wire logic init_enable,
  input wire logic init_retry,
  input wire logic init_rmw,
  input wire logic wr_en,
  input wire mem_port_access_pkg::word_t wr_data,
  output mem_port_access_pkg::word_t rd_data,
  output logic enable,
  output logic retry_enable,
  output logic read_modify_write_enable
);
  // Straps load through a clocked reset, never an async one
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      enable <= init_enable;
      retry_enable <= init_retry;
      read_modify_write_enable <= init_rmw;
    end
    else if (wr_en)
    begin
      enable <= wr_data[`TM_ENABLE_BIT];
      retry_enable <= wr_data[`TM_RETRY_BIT];
      read_modify_write_enable <= wr_data[`TM_RMW_BIT];
    end
  end

  always_comb
  begin
    rd_data = '0;
    rd_data[`TM_SIZE_MSB:`TM_SIZE_LSB] = size_code;
    rd_data[`TM_RETRY_BIT] = retry_enable;
    rd_data[`TM_RMW_BIT] = read_modify_write_enable;
    rd_data[`TM_ENABLE_BIT] = enable;
  end
endmodule : tight_mem_ctrl_reg
`default_nettype wire

// ---- rtl/access_router.sv ----
`timescale 1ns/1ps
`default_nettype none
module access_router
  import mem_port_access_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire logic region_hit,
  input wire logic port_enable,
  output logic route_valid,
  output mem_port_access_pkg::route_t route
);
  // Registered route so top outputs come from flip-flops
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      route_valid <= 1'b0;
      route <= ROUTE_AXI;
    end
    else
    begin
      route_valid <= req_valid && region_hit;
      route <= port_enable ? ROUTE_TIGHT : ROUTE_AXI;
    end
  end
endmodule : access_router
`default_nettype wire

// ---- rtl/memory_port_access_control.sv ----
// Summary of operation
// - Memory control registers show read-only four-bit size code at bits 6:3.
// - Retry enable bit 2 makes the memory port honour retry.
// - Read-modify-write bit 1 turns sub-chunk writes into read-modify-write.
// - Enable bit 0 clear sends that memory region's accesses to AXI.
// - Separate, identically laid out registers for instruction and data memory.
// - Memory enable bits reset from external strap inputs.
// - Retry and read-modify-write bits reset from external strap inputs.
// - Peripheral port register shows read-only three-bit size at bits 3:1.
// - Peripheral port enable clear sends its accesses to AXI.
// - Peripheral port enable bit resets from an external strap input.
// - Cache control resets to zero with ECC, else 0x2.
`timescale 1ns/1ps
`default_nettype none
`include "mem_port_access_defs.svh"
module memory_port_access_control
  import mem_port_access_pkg::*;
#(
  parameter bit CACHE_ECC_PRESENT = 1'b1,
  parameter bit DATA_CACHE_PRESENT = 1'b1,
  parameter logic [3:0] INSTR_SIZE_CODE = 4'h3,
  parameter logic [3:0] DATA_SIZE_CODE = 4'h3,
  parameter logic [2:0] PERIPH_SIZE_CODE = 3'h1
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic init_instr_enable,
  input wire logic init_instr_retry,
  input wire logic init_instr_rmw,
  input wire logic init_data_enable,
  input wire logic init_data_retry,
  input wire logic init_data_rmw,
  input wire logic init_periph_enable,
  input wire logic reg_sel,
  input wire logic reg_write,
  input wire logic reg_privileged,
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [4:0] async_fault,
  input wire logic [1:0] axi_fault_type,
  input wire logic instr_req,
  input wire logic instr_hit,
  input wire logic data_req,
  input wire logic data_hit,
  input wire logic periph_req,
  output logic [31:0] reg_rdata,
  output logic reg_error,
  output logic instr_route_valid,
  output mem_port_access_pkg::route_t instr_route,
  output logic data_route_valid,
  output mem_port_access_pkg::route_t data_route,
  output logic periph_route_valid,
  output mem_port_access_pkg::route_t periph_route,
  output logic instr_retry_enable,
  output logic instr_rmw_enable,
  output logic data_retry_enable,
  output logic data_rmw_enable,
  output logic force_write_through,
  output logic ecc_disable,
  output logic shared_write_through,
  output logic [4:0] prio_init_count,
  output logic [1:0] prio_control
);
  import mem_port_access_pkg::*;

  // ************************************************************
  // Access decode
  // ************************************************************
  function automatic logic addr_is(input logic [31:0] a, input logic [31:0] target);
    addr_is = (a == target);
  endfunction : addr_is

  logic access_ok;
  logic wr_ok;
  logic hit_instr;
  logic hit_data;
  logic hit_periph;
  logic hit_cache;
  logic hit_prio;
  logic hit_fault;
  logic hit_any;

  // Unprivileged accesses see nothing and change nothing
  assign access_ok = reg_sel && reg_privileged;
  assign wr_ok = access_ok && reg_write;
  assign hit_instr = addr_is(reg_addr, `ADDR_INSTR_TIGHT_MEM_CTRL);
  assign hit_data = addr_is(reg_addr, `ADDR_DATA_TIGHT_MEM_CTRL);
  assign hit_periph = addr_is(reg_addr, `ADDR_PERIPH_PORT_CTRL);
  assign hit_cache = addr_is(reg_addr, `ADDR_CACHE_CTRL);
  assign hit_prio = addr_is(reg_addr, `ADDR_SLAVE_PORT_PRIORITY_CTRL);
  assign hit_fault = addr_is(reg_addr, `ADDR_AUX_BUS_FAULT_STATUS);
  assign hit_any = hit_instr | hit_data | hit_periph | hit_cache | hit_prio | hit_fault;

  // ************************************************************
  // Tightly coupled memory control
  // ************************************************************
  word_t instr_rd;
  word_t data_rd;
  logic instr_enable;
  logic data_enable;

  tight_mem_ctrl_reg u_instr_ctrl (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .size_code(INSTR_SIZE_CODE),
    .init_enable(init_instr_enable),
    .init_retry(init_instr_retry),
    .init_rmw(init_instr_rmw),
    .wr_en(wr_ok && hit_instr),
    .wr_data(reg_wdata),
    .rd_data(instr_rd),
    .enable(instr_enable),
    .retry_enable(instr_retry_enable),
    .read_modify_write_enable(instr_rmw_enable)
  );

  tight_mem_ctrl_reg u_data_ctrl (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .size_code(DATA_SIZE_CODE),
    .init_enable(init_data_enable),
    .init_retry(init_data_retry),
    .init_rmw(init_data_rmw),
    .wr_en(wr_ok && hit_data),
    .wr_data(reg_wdata),
    .rd_data(data_rd),
    .enable(data_enable),
    .retry_enable(data_retry_enable),
    .read_modify_write_enable(data_rmw_enable)
  );

  // ************************************************************
  // Peripheral port control
  // ************************************************************
  logic periph_enable;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      periph_enable <= init_periph_enable;
    else if (wr_ok && hit_periph)
      periph_enable <= reg_wdata[`PP_ENABLE_BIT];
  end

  // ************************************************************
  // Cache control
  // ************************************************************
  logic cache_ecc_dis;
  // Literals cannot be bit-selected, so reset words are named first
  localparam word_t CACHE_RST = CACHE_ECC_PRESENT ? `CACHE_CTRL_RST_ECC : `CACHE_CTRL_RST_NO_ECC;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      cache_ecc_dis <= CACHE_RST[`CC_ECC_DIS_BIT];
      force_write_through <= CACHE_RST[`CC_FORCE_WT_BIT];
      shared_write_through <= CACHE_RST[`CC_SHARED_WT_BIT];
    end
    else if (wr_ok && hit_cache)
    begin
      // Without ECC the disable bit is stuck at one
      if (CACHE_ECC_PRESENT)
        cache_ecc_dis <= reg_wdata[`CC_ECC_DIS_BIT];
      force_write_through <= DATA_CACHE_PRESENT && reg_wdata[`CC_FORCE_WT_BIT];
      shared_write_through <= DATA_CACHE_PRESENT && reg_wdata[`CC_SHARED_WT_BIT];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      ecc_disable <= 1'b0;
    else
      ecc_disable <= cache_ecc_dis;
  end

  // ************************************************************
  // Slave priority control
  // ************************************************************
  localparam word_t PRIO_RST = `SLAVE_PRIO_RST;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      prio_init_count <= PRIO_RST[`SP_INIT_COUNT_MSB:`SP_INIT_COUNT_LSB];
      prio_control <= PRIO_RST[`SP_CTL_MSB:`SP_CTL_LSB];
    end
    else if (wr_ok && hit_prio)
    begin
      prio_init_count <= reg_wdata[`SP_INIT_COUNT_MSB:`SP_INIT_COUNT_LSB];
      prio_control <= reg_wdata[`SP_CTL_MSB:`SP_CTL_LSB];
    end
  end

  // ************************************************************
  // Auxiliary fault status
  // ************************************************************
  logic [4:0] fault_sticky;
  logic [1:0] fault_axi_type;
  localparam word_t FAULT_RST = `AUX_FAULT_RST;

  // A fault arriving with the clearing write is kept: set wins
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      fault_sticky <= FAULT_RST[`AF_STICKY_MSB:0];
      fault_axi_type <= FAULT_RST[`AF_VALID_MSB:`AF_VALID_MSB - 1];
    end
    else
    begin
      fault_sticky <= ((wr_ok && hit_fault) ? 5'h00 : fault_sticky) | async_fault;
      if (async_fault[3])
        fault_axi_type <= axi_fault_type;
    end
  end

  // ************************************************************
  // Read path
  // ************************************************************
  word_t next_rdata;

  always_comb
  begin
    next_rdata = '0;
    if (hit_instr)
      next_rdata = instr_rd;
    else if (hit_data)
      next_rdata = data_rd;
    else if (hit_periph)
    begin
      next_rdata[`PP_SIZE_MSB:`PP_SIZE_LSB] = PERIPH_SIZE_CODE;
      next_rdata[`PP_ENABLE_BIT] = periph_enable;
    end
    else if (hit_cache)
    begin
      next_rdata[`CC_FORCE_WT_BIT] = force_write_through;
      next_rdata[`CC_ECC_DIS_BIT] = cache_ecc_dis;
      next_rdata[`CC_SHARED_WT_BIT] = shared_write_through;
    end
    else if (hit_prio)
    begin
      next_rdata[`SP_INIT_COUNT_MSB:`SP_INIT_COUNT_LSB] = prio_init_count;
      next_rdata[`SP_CTL_MSB:`SP_CTL_LSB] = prio_control;
    end
    else if (hit_fault)
    begin
      next_rdata[`AF_VALID_MSB:`AF_VALID_MSB - 1] = fault_axi_type;
      next_rdata[`AF_STICKY_MSB:0] = fault_sticky;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      reg_rdata <= 32'h00000000;
      reg_error <= 1'b0;
    end
    else
    begin
      reg_rdata <= (access_ok && !reg_write) ? next_rdata : 32'h00000000;
      reg_error <= reg_sel && !(reg_privileged && hit_any);
    end
  end

  // ************************************************************
  // Access steering
  // ************************************************************
  access_router u_instr_route (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .req_valid(instr_req),
    .region_hit(instr_hit),
    .port_enable(instr_enable),
    .route_valid(instr_route_valid),
    .route(instr_route)
  );

  access_router u_data_route (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .req_valid(data_req),
    .region_hit(data_hit),
    .port_enable(data_enable),
    .route_valid(data_route_valid),
    .route(data_route)
  );

  access_router u_periph_route (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .req_valid(periph_req),
    .region_hit(1'b1),
    .port_enable(periph_enable),
    .route_valid(periph_route_valid),
    .route(periph_route)
  );
endmodule : memory_port_access_control
`default_nettype wire

// ---- tb/access_control_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "mem_port_access_defs.svh"
module access_control_chk
  import mem_port_access_pkg::*;
#(
  parameter logic [3:0] INSTR_SIZE_CODE = 4'h3,
  parameter logic [2:0] PERIPH_SIZE_CODE = 3'h1
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic reg_sel,
  input wire logic reg_write,
  input wire logic reg_privileged,
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic instr_req,
  input wire logic instr_hit,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_error,
  input wire logic instr_route_valid,
  input wire mem_port_access_pkg::route_t instr_route,
  input wire mem_port_access_pkg::route_t periph_route,
  input wire logic instr_retry_enable,
  input wire logic instr_rmw_enable
);
  // ************
  // Port checks
  // ************
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic rd;
  logic wr;
  assign rd = reg_sel && reg_privileged && !reg_write;
  assign wr = reg_sel && reg_privileged && reg_write;
  AST_ROUTE_VALID: assert property (instr_req && instr_hit |=> instr_route_valid)
    else $error("instr route valid missing");
  AST_UNPRIV: assert property (reg_sel && !reg_privileged |=> reg_error && reg_rdata == 32'h0)
    else $error("unprivileged access not refused");
  AST_IDLE: assert property (!reg_sel |=> reg_rdata == 32'h0 && !reg_error)
    else $error("read data without request");
  AST_UNMAPPED: assert property (reg_sel && reg_addr == 32'hE000EFA4 |=> reg_error)
    else $error("unmapped access not refused");
  AST_ITM_SIZE: assert property (rd && reg_addr == `ADDR_INSTR_TIGHT_MEM_CTRL
    |=> reg_rdata[31:3] == {25'h0, INSTR_SIZE_CODE}) else $error("memory size field wrong");
  AST_PP_SIZE: assert property (rd && reg_addr == `ADDR_PERIPH_PORT_CTRL
    |=> reg_rdata[31:1] == {28'h0, PERIPH_SIZE_CODE}) else $error("port size field wrong");
  AST_ITM_BITS: assert property (wr && reg_addr == `ADDR_INSTR_TIGHT_MEM_CTRL
    |=> instr_retry_enable == $past(reg_wdata[2]) && instr_rmw_enable == $past(reg_wdata[1]))
    else $error("retry or rmw bit not written");
  AST_ITM_ROUTE: assert property (wr && reg_addr == `ADDR_INSTR_TIGHT_MEM_CTRL |-> ##2
    instr_route == ($past(reg_wdata[0], 2) ? ROUTE_TIGHT : ROUTE_AXI))
    else $error("instr route ignores enable");
  AST_PP_ROUTE: assert property (wr && reg_addr == `ADDR_PERIPH_PORT_CTRL |-> ##2
    periph_route == ($past(reg_wdata[0], 2) ? ROUTE_TIGHT : ROUTE_AXI))
    else $error("periph route ignores enable");
endmodule : access_control_chk
bind memory_port_access_control access_control_chk #(.INSTR_SIZE_CODE(INSTR_SIZE_CODE),
  .PERIPH_SIZE_CODE(PERIPH_SIZE_CODE)) u_chk (.sys_clk, .rst_n, .reg_sel, .reg_write,
  .reg_privileged, .reg_addr, .reg_wdata, .instr_req, .instr_hit, .reg_rdata, .reg_error,
  .instr_route_valid, .instr_route, .periph_route, .instr_retry_enable, .instr_rmw_enable);
`default_nettype wire

// ---- tb/access_source.sv ----
`timescale 1ns/1ps
`default_nettype none
module access_source
(
  input wire logic sys_clk,
  input wire logic rst_n,
  output logic instr_req,
  output logic instr_hit,
  output logic data_req,
  output logic data_hit,
  output logic periph_req,
  output logic [4:0] async_fault,
  output logic [1:0] axi_fault_type
);
  // ************
  // Requesters
  // ************
  // Quiet in reset so no request leaks across a restart
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      {periph_req, data_hit, data_req, instr_hit, instr_req} <= 5'h0;
      async_fault <= 5'h0;
      axi_fault_type <= 2'h0;
    end
    else
    begin
      {periph_req, data_hit, data_req, instr_hit, instr_req} <= 5'($urandom);
      // Sparse faults so that clears are seen between them
      async_fault <= ($urandom % 16 == 0) ? 5'($urandom) : 5'h0;
      axi_fault_type <= 2'($urandom);
    end
  end
endmodule : access_source
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import mem_port_access_pkg::*;
  // ************
  // Bench
  // ************
  localparam logic [3:0] TSZ = 4'h3;
  localparam logic [2:0] PSZ = 3'h1;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [6:0] strap = 7'h0;
  logic reg_sel = 1'b0;
  logic reg_write = 1'b0;
  logic reg_privileged = 1'b0;
  logic [31:0] reg_addr = 32'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic instr_req, instr_hit, data_req, data_hit, periph_req, reg_error;
  logic instr_route_valid, data_route_valid, periph_route_valid;
  logic [31:0] reg_rdata;
  route_t instr_route, data_route, periph_route;
  logic data_retry_enable, data_rmw_enable, instr_retry_enable, instr_rmw_enable;
  logic force_write_through, ecc_disable, shared_write_through;
  logic [4:0] prio_init_count;
  logic [1:0] prio_control;
  logic [4:0] async_fault;
  logic [1:0] axi_fault_type;
  logic [4:0] f_now = 5'h0;
  logic [4:0] f_nxt = 5'h0;
  logic [1:0] t_now = 2'h0;
  logic [1:0] t_nxt = 2'h0;
  bit ecc_prev = 1'b0;
  logic [15:0] ctl_got, ctl_exp;
  int errors = 0;
  int tests_run = 0;
  int cycles = 0;
  int m [7];
  int mask [7] = '{32'h7, 32'h7, 32'h1, 32'h7, 32'hF803, 32'h0, 32'h0};
  logic [31:0] addrs [8] = '{32'hE000EF90, 32'hE000EF94, 32'hE000EF98, 32'hE000EF9C,
    32'hE000EFA0, 32'hE000EFA4, 32'hE000EFA8, 32'hE000EF00};
  bit live = 1'b0;
  bit [2:0] rq, en;
  always #5 sys_clk = ~sys_clk;
  access_source u_src (.sys_clk, .rst_n, .instr_req, .instr_hit, .data_req, .data_hit,
    .periph_req, .async_fault, .axi_fault_type);
  memory_port_access_control #(.INSTR_SIZE_CODE(TSZ), .DATA_SIZE_CODE(TSZ),
    .PERIPH_SIZE_CODE(PSZ)) DUT (.sys_clk, .rst_n, .init_instr_enable(strap[0]),
    .init_instr_rmw(strap[1]), .init_instr_retry(strap[2]), .init_data_enable(strap[3]),
    .init_data_rmw(strap[4]), .init_data_retry(strap[5]), .init_periph_enable(strap[6]),
    .reg_sel, .reg_write, .reg_privileged, .reg_addr, .reg_wdata, .async_fault,
    .axi_fault_type, .instr_req, .instr_hit, .data_req, .data_hit, .periph_req,
    .reg_rdata, .reg_error, .instr_route_valid, .instr_route, .data_route_valid, .data_route,
    .periph_route_valid, .periph_route, .instr_retry_enable, .instr_rmw_enable,
    .data_retry_enable, .data_rmw_enable, .force_write_through, .ecc_disable,
    .shared_write_through, .prio_init_count, .prio_control);
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_reg
  task automatic chk_port(input logic [2:0] got, input logic [2:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_port
  task automatic chk_ctl(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_ctl
  task automatic acc(input logic w, input logic p, input logic [31:0] a, input logic [31:0] d);
    int i;
    bit ok;
    i = int'((a - 32'hE000EF90) >> 2);
    ok = p && a[1:0] == 2'h0 && a >= 32'hE000EF90 && a <= 32'hE000EFA8 && i != 5;
    @(posedge sys_clk);
    reg_sel <= 1'b1;
    reg_write <= w;
    reg_privileged <= p;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_sel <= 1'b0;
    #1;
    // Read-only size codes are merged in here, never stored
    chk_reg(reg_rdata, (ok && !w) ? m[i] | (i < 2 ? TSZ << 3 : i == 2 ? PSZ << 1 : 0) : 0);
    chk_reg({31'h0, reg_error}, {31'h0, !ok});
    if (ok && w)
    begin
      m[i] = (m[i] & ~mask[i]) | (d & mask[i]);
    end
  endtask : acc
  task results;
    if (errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results
  // Routes lag the enable bits by one edge, so the model enables are sampled a cycle late
  always @(negedge sys_clk)
  begin
    if (rst_n && live)
    begin
      chk_port({instr_route_valid, instr_route}, {rq[0], en[0] ? ROUTE_TIGHT : ROUTE_AXI});
      chk_port({data_route_valid, data_route}, {rq[1], en[1] ? ROUTE_TIGHT : ROUTE_AXI});
      chk_port({periph_route_valid, periph_route}, {rq[2], en[2] ? ROUTE_TIGHT : ROUTE_AXI});
      ctl_got = {2'h0, data_retry_enable, data_rmw_enable, instr_retry_enable, instr_rmw_enable,
        force_write_through, ecc_disable, shared_write_through, prio_init_count, prio_control};
      ctl_exp = {2'h0, m[1][2:1], m[0][2:1], m[3][2], ecc_prev, m[3][0], m[4][15:11], m[4][1:0]};
      chk_ctl(ctl_got, ctl_exp);
    end
    live = rst_n;
    rq = {periph_req, data_req && data_hit, instr_req && instr_hit};
    en = {m[2][0], m[1][0], m[0][0]};
    // The ecc disable pin trails its register bit by one edge
    ecc_prev = m[3][1];
    // Sticky fault model: a clear and a new fault in one cycle keep the fault
    f_now = f_nxt;
    t_now = t_nxt;
    m[6] = {t_now, 3'h0, f_now};
    if (!rst_n)
    begin
      f_nxt = 5'h0;
      t_nxt = 2'h0;
    end
    else
    begin
      f_nxt = ((reg_sel && reg_privileged && reg_write && reg_addr == 32'hE000EFA8) ? 5'h0 : f_now)
        | async_fault;
      t_nxt = async_fault[3] ? axi_fault_type : t_now;
    end
  end
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      errors++;
      results();
    end
  end
  initial
  begin
    void'($urandom(32'hFAA12673));
    repeat (2)
    begin
      @(posedge sys_clk);
      rst_n <= 1'b0;
      strap <= 7'($urandom);
      repeat (10) @(posedge sys_clk);
      m = '{strap[2:0], strap[5:3], strap[6], 0, 0, 0, 0};
      rst_n <= 1'b1;
      foreach (addrs[k]) acc(1'b0, 1'b1, addrs[k], 32'h0);
      repeat (60) acc(1'($urandom), ($urandom % 4) != 0, addrs[$urandom % 8], $urandom);
    end
    results();
  end
endmodule : testbench
`default_nettype wire
